//--- rtl/rpw_pkg.sv
// Constants shared by the RGB pixel write port design files.
package rpw_pkg;

	// ********************************************************
	// Register byte offsets.
	// ********************************************************
	localparam logic [7:0] ADDR_CTRL  = 8'h00; // Control and polarity.
	localparam logic [7:0] ADDR_START = 8'h04; // Frame start address.
	localparam logic [7:0] ADDR_STAT  = 8'h08; // Live port state.
	localparam logic [7:0] ADDR_LINES = 8'h0c; // Lines per frame.

	// ********************************************************
	// Control register field positions.
	// ********************************************************
	localparam int CTRL_MODE = 0;  // Display timed from the RGB port.
	localparam int CTRL_PATH = 1;  // ram_path_select.
	localparam int CTRL_FAST = 2;  // fast_write_enable.
	localparam int CTRL_WID  = 4;  // rgb_width_select, two bits.
	localparam int CTRL_VPOL = 8;  // vsync_polarity.
	localparam int CTRL_HPOL = 9;  // hsync_polarity.
	localparam int CTRL_EPOL = 10; // enable_polarity.
	localparam int CTRL_DPOL = 11; // dotclk_polarity.
	localparam int CTRL_PART = 12; // Partial display request.
	localparam int CTRL_SCRL = 13; // Scroll request.

	// ********************************************************
	// Reset values and widths.
	// ********************************************************
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [16:0] START_RST = 17'h0_0000;
	localparam logic [9:0]  LINES_RST = 10'h1b0;
	localparam int          AW        = 17; // RAM address width.
	localparam int          DW        = 18; // Pixel width.
	localparam int          LW        = 10; // Line counter width.

	// ********************************************************
	// Bus width codes and frame states.
	// ********************************************************
	localparam logic [1:0] WID_18 = 2'h0;
	localparam logic [1:0] WID_16 = 2'h1;
	localparam logic [1:0] WID_6  = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_FPORCH = 2'b01,
		ST_ACTIVE = 2'b10
	} rpw_state_e;

endpackage : rpw_pkg

//--- rtl/rpw_sync.sv
// Two-stage synchroniser for the RGB port pins.
`timescale 1ns/1ps
module rpw_sync #(
	parameter int W = 22
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] sync
);
	// ********************************************************
	// Synchroniser stages.
	// ********************************************************
	logic [W-1:0] s1_q; // First stage, read only by the second.
	logic [W-1:0] s1_d; // Next first stage.
	logic [W-1:0] s2_d; // Next second stage.

	// The next stage values are the pin and the first stage.
	always_comb begin
		s1_d = pin;
		s2_d = s1_q;
	end

	// Both stages reset to zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			sync <= '0;
		end else begin
			s1_q <= s1_d;
			sync <= s2_d;
		end
	end

endmodule : rpw_sync

//--- rtl/rpw_pix.sv
// Pixel assembler: beat counting and bus width handling.
`timescale 1ns/1ps
module rpw_pix
	import rpw_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          clr,
	input  wire logic          take,
	input  wire logic [1:0]    mode,
	input  wire logic [DW-1:0] db,
	output logic               pix_valid,
	output logic      [DW-1:0] pix_data,
	output logic      [1:0]    beat
);
	// ********************************************************
	// Assembly state.
	// ********************************************************
	logic [5:0]    red_q, red_d;     // Held red beat.
	logic [5:0]    grn_q, grn_d;     // Held green beat.
	logic [1:0]    beat_d;           // Next beat.
	logic          valid_d;          // Next pixel strobe.
	logic [DW-1:0] data_d;           // Next pixel.

	// In width codes 00, 01 and 10 each taken transfer completes a pixel or holds a beat; code 11 drops it.
	always_comb begin
		beat_d  = beat;
		red_d   = red_q;
		grn_d   = grn_q;
		valid_d = 1'b0;
		data_d  = pix_data;
		if (clr) begin
			beat_d = 2'h0;
		end else if (take) begin
			case (mode)
				WID_6: begin
					// Upper six lines carry red, green, blue in turn.
					case (beat)
						2'h0: begin
							red_d  = db[17:12];
							beat_d = 2'h1;
						end
						2'h1: begin
							grn_d  = db[17:12];
							beat_d = 2'h2;
						end
						default: begin
							data_d  = {red_q, grn_q, db[17:12]};
							valid_d = 1'b1;
							beat_d  = 2'h0;
						end
					endcase
				end
				WID_16: begin
					// Split bus; red and blue copy their top bit down.
					data_d  = {db[17:13], db[17], db[12:10], db[8:6],
						db[5:1], db[5]};
					valid_d = 1'b1;
				end
				WID_18: begin
					data_d  = db;
					valid_d = 1'b1;
				end
				default: begin
					valid_d = 1'b0;
				end
			endcase
		end
	end

	// Register the assembly state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			beat      <= 2'h0;
			red_q     <= 6'h00;
			grn_q     <= 6'h00;
			pix_valid <= 1'b0;
			pix_data  <= 18'h0_0000;
		end else begin
			beat      <= beat_d;
			red_q     <= red_d;
			grn_q     <= grn_d;
			pix_valid <= valid_d;
			pix_data  <= data_d;
		end
	end

	// ********************************************************
	// Checks.
	// ********************************************************
	a_beat_reset: assert property (@(posedge pclk) disable iff (!presetn)
		clr |=> beat == 2'h0)
		else $error("Beat counter not reset by frame start.");
	a_beat_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!take && !clr |=> $stable(beat) && !pix_valid)
		else $error("Beat moved without a transfer.");
	a_six_third: assert property (@(posedge pclk) disable iff (!presetn)
		take && !clr && mode == WID_6 && beat == 2'h2
		|=> pix_valid && pix_data[5:0] == $past(db[17:12]))
		else $error("Third six-bit beat gave no pixel.");
	a_six_early: assert property (@(posedge pclk) disable iff (!presetn)
		take && !clr && mode == WID_6 && beat != 2'h2
		|=> !pix_valid)
		else $error("Pixel completed before third beat.");
	a_wide_direct: assert property (@(posedge pclk) disable iff (!presetn)
		take && !clr && mode == WID_18 |=> pix_valid
		&& pix_data == $past(db))
		else $error("Eighteen-bit transfer not passed whole.");
	c_six_pixel: cover property (@(posedge pclk) disable iff (!presetn)
		mode == WID_6 && pix_valid);

endmodule : rpw_pix

//--- rtl/rpw_port.sv
// RGB pixel write port with APB control registers.
//
// Overview of operation
// - Display timing follows incoming sync and dot clock.
// - Each of four inputs has polarity bit.
// - Pixels written only while enable is active.
// - Concurrent RAM accesses are unsupported; avoid them.
// - Width code 10 selects six-bit upper lines.
// - Six-bit mode builds pixels from three beats.
// - Beat counter resets at each frame start.
// - Width code 01 takes sixteen-bit pixels.
// - Width code 00 takes eighteen-bit pixels.
// - Configuration only through registers; port carries pixels.
// - Partial display and scroll off in RGB mode.
// - Panel timing ticks come from dot clock.
// - Front porch holds until next vertical sync.
// - Frame start reloads address from start register.
`timescale 1ns/1ps
module rpw_port (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic [7:0]      paddr,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic            vsync_in,
	input  wire logic            hsync_in,
	input  wire logic            enable_in,
	input  wire logic            dotclk_in,
	input  wire logic [17:0]     db_in,
	output logic                 ram_we,
	output logic      [16:0]     ram_addr,
	output logic      [17:0]     ram_wdata,
	output logic                 fast_write,
	output logic                 panel_tick,
	output logic                 line_start,
	output logic                 frame_start,
	output logic                 in_front_porch,
	output logic                 partial_en,
	output logic                 scroll_en
);
	import rpw_pkg::*;

	// ********************************************************
	// Pin synchronisers and edge detection.
	// ********************************************************
	logic [21:0]   pins_s;       // Synchronised pins.
	logic          vs_act;       // Vertical sync at its active level.
	logic          hs_act;       // Horizontal sync at its active level.
	logic          en_act;       // Data enable at its active level.
	logic          dk_norm;      // Dot clock, taken edge made rising.
	logic [2:0]    lvl_q, lvl_d; // Previous vs, hs and dot levels.
	logic          vs_fall;      // Start of a vertical sync pulse.
	logic          hs_fall;      // Start of a horizontal sync pulse.
	logic          dot_edge;     // Taken dot clock edge.
	logic          take;         // A transfer is taken this cycle.

	// Every pin, data included, sees the same two-stage latency.
	rpw_sync #(.W(22)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     ({vsync_in, hsync_in, enable_in, dotclk_in, db_in}),
		.sync    (pins_s)
	);

	// ********************************************************
	// Registers.
	// ********************************************************
	logic [31:0]   ctrl_q, ctrl_d;     // Control and polarity.
	logic [AW-1:0] start_q, start_d;   // ram_start_address.
	logic [LW-1:0] lines_q, lines_d;   // Lines in one frame.
	logic [31:0]   rdata_d;            // Next read data.
	logic          rdy_d, err_d;       // Next pready and pslverr.
	logic          hit;                // Address is mapped.
	logic          wr_now;             // Write completes this edge.
	logic          rgb_mode;           // Display from the RGB port.
	logic          path_sel;           // RAM belongs to the RGB port.
	logic [1:0]    width;              // Bus width code.
	logic [1:0]    beat;               // Six-bit beat position.
	logic          pix_valid;          // Assembled pixel strobe.
	logic [DW-1:0] pix_data;           // Assembled pixel.
	rpw_state_e    state_q, state_d;   // Frame state.
	logic [LW-1:0] line_q, line_d;     // Lines seen in this frame.
	logic [AW-1:0] addr_q, addr_d;     // RAM address counter.

	// Polarity bits set the active level of each input.
	always_comb begin
		rgb_mode = ctrl_q[CTRL_MODE];
		path_sel = ctrl_q[CTRL_PATH];
		width    = ctrl_q[CTRL_WID+1:CTRL_WID];
		vs_act   = ~(pins_s[21] ^ ctrl_q[CTRL_VPOL]);
		hs_act   = ~(pins_s[20] ^ ctrl_q[CTRL_HPOL]);
		en_act   = ~(pins_s[19] ^ ctrl_q[CTRL_EPOL]);
		dk_norm  = pins_s[18] ^ ctrl_q[CTRL_DPOL];
		lvl_d    = {vs_act, hs_act, dk_norm};
		vs_fall  = vs_act & ~lvl_q[2];
		hs_fall  = hs_act & ~lvl_q[1];
		dot_edge = dk_norm & ~lvl_q[0];
	end

	// The APB slave answers with one wait state; unmapped is an error.
	always_comb begin
		ctrl_d  = ctrl_q;
		start_d = start_q;
		lines_d = lines_q;
		hit     = (paddr == ADDR_CTRL) || (paddr == ADDR_START)
			|| (paddr == ADDR_STAT) || (paddr == ADDR_LINES);
		rdy_d   = psel & penable & ~pready;
		err_d   = psel & penable & ~pready & ~hit;
		wr_now  = psel & penable & pready & pwrite & ~pslverr;
		rdata_d = prdata;
		if (psel && penable && !pready) begin
			case (paddr)
				ADDR_CTRL:  rdata_d = ctrl_q;
				ADDR_START: rdata_d = {15'h0000, start_q};
				ADDR_STAT:  rdata_d = {11'h000, state_q, beat, addr_q};
				ADDR_LINES: rdata_d = {22'h00_0000, lines_q};
				default:    rdata_d = 32'h0000_0000;
			endcase
		end
		// Settings arrive only over the bus, never over the pixel lines.
		if (wr_now) begin
			case (paddr)
				ADDR_CTRL:  ctrl_d  = pwdata & 32'h0000_3f37;
				ADDR_START: start_d = pwdata[AW-1:0];
				ADDR_LINES: lines_d = pwdata[LW-1:0];
				default:    ctrl_d  = ctrl_q;
			endcase
		end
	end

	// ********************************************************
	// Frame sequencing and address counter.
	// ********************************************************

	// Frames start at vertical sync and end after the programmed lines.
	always_comb begin
		state_d = state_q;
		line_d  = line_q;
		addr_d  = addr_q;
		case (state_q)
			ST_IDLE: begin
				if (rgb_mode) begin
					state_d = ST_FPORCH;
				end
			end
			ST_FPORCH: begin
				// Stay in the porch until vertical sync comes.
				if (vs_fall) begin
					state_d = ST_ACTIVE;
					line_d  = '0;
				end
			end
			ST_ACTIVE: begin
				if (hs_fall) begin
					line_d = line_q + 1'b1;
					if (line_d >= lines_q) begin
						state_d = ST_FPORCH;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (!rgb_mode) begin
			state_d = ST_IDLE;
		end
		// The address restarts each frame; it moves only per pixel.
		if (rgb_mode && vs_fall) begin
			addr_d = start_q;
		end else if (pix_valid) begin
			addr_d = addr_q + 1'b1;
		end
	end

	// Transfers count only on dot edges with enable active and a path.
	assign take = rgb_mode & dot_edge & en_act & path_sel
		& (state_q == ST_ACTIVE);

	rpw_pix u_pix (
		.pclk      (pclk),
		.presetn   (presetn),
		.clr       (vs_fall),
		.take      (take),
		.mode      (width),
		.db        (pins_s[17:0]),
		.pix_valid (pix_valid),
		.pix_data  (pix_data),
		.beat      (beat)
	);

	// All state outside u_sync and u_pix, and every output, are registered here.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q         <= CTRL_RST;
			start_q        <= START_RST;
			lines_q        <= LINES_RST;
			lvl_q          <= 3'h7;
			prdata         <= 32'h0000_0000;
			pready         <= 1'b0;
			pslverr        <= 1'b0;
			state_q        <= ST_IDLE;
			line_q         <= '0;
			addr_q         <= START_RST;
			ram_we         <= 1'b0;
			ram_addr       <= START_RST;
			ram_wdata      <= 18'h0_0000;
			fast_write     <= 1'b0;
			panel_tick     <= 1'b0;
			line_start     <= 1'b0;
			frame_start    <= 1'b0;
			in_front_porch <= 1'b0;
			partial_en     <= 1'b0;
			scroll_en      <= 1'b0;
		end else begin
			ctrl_q         <= ctrl_d;
			start_q        <= start_d;
			lines_q        <= lines_d;
			lvl_q          <= lvl_d;
			prdata         <= rdata_d;
			pready         <= rdy_d;
			pslverr        <= err_d;
			state_q        <= state_d;
			line_q         <= line_d;
			addr_q         <= addr_d;
			ram_we         <= pix_valid & path_sel;
			ram_addr       <= addr_q;
			ram_wdata      <= pix_data;
			fast_write     <= ctrl_q[CTRL_FAST];
			panel_tick     <= rgb_mode & dot_edge;
			line_start     <= rgb_mode & hs_fall;
			frame_start    <= rgb_mode & vs_fall;
			in_front_porch <= state_q == ST_FPORCH;
			partial_en     <= ctrl_q[CTRL_PART] & ~rgb_mode;
			scroll_en      <= ctrl_q[CTRL_SCRL] & ~rgb_mode;
		end
	end

	// ********************************************************
	// Checks.
	// ********************************************************
	a_addr_reload: assert property (@(posedge pclk) disable iff (!presetn)
		rgb_mode && vs_fall |=> addr_q == $past(start_q))
		else $error("Address not reloaded at frame start.");
	a_addr_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!pix_valid && !vs_fall |=> $stable(addr_q))
		else $error("Address moved without a pixel.");
	a_write_enable: assert property (@(posedge pclk) disable iff (!presetn)
		ram_we |-> $past(en_act, 2) && $past(dot_edge, 2))
		else $error("RAM write without enable and dot edge.");
	a_path_gate: assert property (@(posedge pclk) disable iff (!presetn)
		ram_we |-> $past(path_sel, 2))
		else $error("RAM write while system path owns RAM.");
	a_porch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_FPORCH && rgb_mode && !vs_fall
		|=> state_q == ST_FPORCH)
		else $error("Front porch left without vertical sync.");
	a_partial_off: assert property (@(posedge pclk) disable iff (!presetn)
		rgb_mode |=> !partial_en && !scroll_en)
		else $error("Partial or scroll on in RGB mode.");
	a_panel_tick: assert property (@(posedge pclk) disable iff (!presetn)
		panel_tick |-> $past(dot_edge) && $past(rgb_mode))
		else $error("Panel tick not from a dot clock edge.");
	c_reload: cover property (@(posedge pclk) disable iff (!presetn)
		frame_start ##[1:200] ram_we);
	c_porch: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(in_front_porch));
	c_write: cover property (@(posedge pclk) disable iff (!presetn)
		ram_we ##1 !ram_we);

endmodule : rpw_port

//--- test/rpw_video_src.sv
// Behavioural host video source that drives the RGB port pins.
`timescale 1ns/1ps
module rpw_video_src (
	input  wire logic [3:0]  pol,
	output logic             vsync_in,
	output logic             hsync_in,
	output logic             enable_in,
	output logic             dotclk_in,
	output logic      [17:0] db_in
);

	// ********************************************************
	// Logical levels, 1 meaning active; the pins apply polarity.
	// ********************************************************
	logic vs_l = 1'b0; // Vertical sync asserted.
	logic hs_l = 1'b0; // Horizontal sync asserted.
	logic en_l = 1'b0; // Data enable asserted.
	logic dc_l = 1'b0; // Dot clock high phase.

	// Polarity bit 0 is vsync, 1 hsync, 2 enable, 3 dot clock.
	assign vsync_in  = ~vs_l ^ pol[0];
	assign hsync_in  = ~hs_l ^ pol[1];
	assign enable_in = ~en_l ^ pol[2];
	assign dotclk_in = dc_l ^ pol[3];
	initial db_in = 18'h0;

	// One dot period of 80 ns; the clock stands still between calls.
	task automatic beat(input logic [17:0] d, input logic en,
		input logic vs, input logic hs);
		#3;
		vs_l = vs;
		hs_l = hs;
		en_l = en;
		// Idle lines toggle so a stale value is never mistaken for data.
		db_in = en ? d : ~db_in;
		#40;
		dc_l = 1'b1;
		// Falls just before the period ends so no pin moves on a pclk edge.
		#36;
		dc_l = 1'b0;
		#1;
	endtask : beat

endmodule : rpw_video_src

//--- test/tb_top.sv
// Self-checking bench for the RGB pixel write port.
`timescale 1ns/1ps
module tb_top
	import rpw_pkg::*;
;

	// ********************************************************
	// Signals and bench state.
	// ********************************************************
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, e;
	logic        vsync_in, hsync_in, enable_in, dotclk_in;
	logic [17:0] db_in, ram_wdata, acc;
	logic        ram_we, fast_write, panel_tick, line_start;
	logic        frame_start, in_front_porch, partial_en, scroll_en;
	logic [16:0] ram_addr, start, exp_addr;
	logic [3:0]  pol, src_pol;
	logic [1:0]  wid;
	logic        live, path_on;
	logic [34:0] q[$];  // Expected {address, pixel} writes.
	int          mismatches, total_checks, cycles, m, nb, seed;
	int          exp_fs, seen_fs;
	int          exp_ls, seen_ls, exp_pt, seen_pt; // Line and dot pulses.

	rpw_port dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.vsync_in(vsync_in), .hsync_in(hsync_in), .enable_in(enable_in),
		.dotclk_in(dotclk_in), .db_in(db_in), .ram_we(ram_we),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.fast_write(fast_write), .panel_tick(panel_tick),
		.line_start(line_start), .frame_start(frame_start),
		.in_front_porch(in_front_porch), .partial_en(partial_en),
		.scroll_en(scroll_en));

	rpw_video_src src_u (.pol(src_pol), .vsync_in(vsync_in),
		.hsync_in(hsync_in), .enable_in(enable_in),
		.dotclk_in(dotclk_in), .db_in(db_in));

	// ********************************************************
	// Clock, timeout and checking.
	// ********************************************************
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Cuts a hang short well beyond the expected run length.
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("ERROR %0t: run did not finish", $time);
			final_report();
		end
	end

	// Takes the oldest expected write off the queue at each RAM write.
	always @(posedge pclk) begin
		if (frame_start === 1'b1) seen_fs++;
		if (line_start === 1'b1) seen_ls++;
		if (panel_tick === 1'b1) seen_pt++;
		if (ram_we === 1'b1) begin
			if (q.size() == 0) begin
				mismatches++;
				$display("ERROR %0t: write with none expected", $time);
			end else begin
				chk_px({ram_addr, ram_wdata}, q.pop_front());
			end
		end
	end

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: value %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_px(input logic [34:0] got, input logic [34:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: write %h expected %h", $time, got, exp);
		end
	endtask : chk_px

	task final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	// ********************************************************
	// APB master and pixel stimulus.
	// ********************************************************
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, r, e);
		chk(e, 1'b0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic er);
		apb(1'b0, a, 32'($urandom), r, e);
		chk({e, r}, {er, d});
	endtask : rd

	function automatic logic [31:0] ctrl(input logic md, input logic pth);
		return {18'h0, 2'h3, pol, 2'h0, wid, 2'h1, pth, md};
	endfunction : ctrl

	task automatic push(input logic [17:0] v);
		q.push_back({exp_addr, v});
		exp_addr++;
	endtask : push

	// Notes the expected write, then sends one dot period.
	task automatic pix(input logic [17:0] d, input logic en);
		if (en && live) begin
			if (wid == WID_18) push(d);
			if (wid == WID_16) push({d[17:13], d[17], d[12:10], d[8:6],
				d[5:1], d[5]});
			if (wid == WID_6) begin
				acc = {acc[11:0], d[17:12]};
				nb++;
				if (nb == 3) begin
					push(acc);
					nb = 0;
				end
			end
		end
		src_u.beat(d, en, 1'b0, 1'b0);
	endtask : pix

	// Seven beats a line leave a partial pixel in six-bit mode; a whole
	// frame sends six, so every line carries complete pixels.
	task automatic frame(input logic whole);
		int   i;  // Beat within the line.
		int   ln; // Line within the frame.
		logic en; // Enable for this beat.
		exp_addr = start;
		nb = 0;
		live = path_on;
		exp_fs++;
		exp_ls += 2;
		exp_pt += 22;
		src_u.beat(18'h0, 1'b0, 1'b1, 1'b0);
		pix(18'h0, 1'b0);
		for (ln = 0; ln < 2; ln++) begin
			for (i = 0; i < 8; i++) begin
				en = (i != 3) && !(whole && i == 7);
				pix(18'($urandom), en);
			end
			src_u.beat(18'h0, 1'b0, 1'b0, 1'b1);
		end
		live = 1'b0;
		pix(18'($urandom), 1'b1);
		pix(18'h0, 1'b0);
		chk(in_front_porch, 1'b1);
	endtask : frame

	// ********************************************************
	// Main sequence.
	// ********************************************************
	initial begin
		seed = $urandom(47383);
		{presetn, psel, penable, pwrite, live, path_on} = 6'h0;
		{paddr, pwdata, pol, src_pol, wid} = 50'h0;
		{start, exp_addr, acc} = 52'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_CTRL, CTRL_RST, 1'b0);
		rd(ADDR_START, {15'h0, START_RST}, 1'b0);
		rd(ADDR_LINES, {22'h0, LINES_RST}, 1'b0);
		rd(8'h10, 32'h0, 1'b1);
		wr(ADDR_LINES, 32'h2);
		rd(ADDR_LINES, 32'h2, 1'b0);
		for (m = 0; m < 4; m++) begin
			wid = m[1:0];
			pol = 4'($urandom);
			start = 17'($urandom % 32'h1ff00);
			// Polarity changes only while the port is out of RGB mode.
			wr(ADDR_CTRL, ctrl(1'b0, 1'b1));
			src_pol = pol;
			repeat (3) @(posedge pclk);
			chk({fast_write, partial_en, scroll_en}, 3'h7);
			wr(ADDR_START, {15'h0, start});
			wr(ADDR_CTRL, ctrl(1'b1, 1'b1));
			rd(ADDR_CTRL, ctrl(1'b1, 1'b1), 1'b0);
			repeat (3) @(posedge pclk);
			chk({fast_write, partial_en, scroll_en}, 3'h4);
			path_on = 1'b1;
			frame(1'b0);
			frame(1'b1);
			if (m == 0) begin
				wr(ADDR_CTRL, ctrl(1'b1, 1'b0));
				path_on = 1'b0;
				frame(1'b0);
				wr(ADDR_CTRL, ctrl(1'b1, 1'b1));
				path_on = 1'b1;
				frame(1'b1);
			end
			// Porch state, cleared beat and the advanced address read back.
			rd(ADDR_STAT, {11'h0, 2'h1, 2'h0, exp_addr}, 1'b0);
		end
		repeat (40) @(posedge pclk);
		chk(q.size(), 0);
		chk(seen_fs, exp_fs);
		chk(seen_ls, exp_ls);
		chk(seen_pt, exp_pt);
		final_report();
	end

endmodule : tb_top
